// *** rot_mem_model.sv ***
// data memory stand-in that serves the operand byte and takes write-backs
module rot_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // operand loaded by the decoder side
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  // memory ports of the rotate unit
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic [7:0]      mem_rdata
);
  logic [7:0] byte_r;

  // stored byte follows loads first, then write-backs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) byte_r <= 8'h00;
    else if (load) byte_r <= load_data;
    else if (mem_we) byte_r <= mem_wdata;
  end

  // a fresh load is visible at once, as an addressed read would be
  assign mem_rdata = load ? load_data : byte_r;
endmodule // rot_mem_model

// *** rot_pkg.sv ***
// package of opcodes and reset values for the rotate unit
package rot_pkg;

  // rotate operations presented by the decoder
  typedef enum logic [2:0] {
    ROT_NONE,
    ROT_LC_MEM,
    ROT_LC_WORK,
    ROT_R_MEM,
    ROT_R_WORK,
    ROT_RC_MEM,
    ROT_RC_WORK,
    ROT_L_MEM
  } rot_op_e;

  localparam int unsigned ROT_WIDTH = 8;
  localparam int unsigned ROT_MSB   = 7;
  localparam int unsigned ROT_LSB   = 0;
  localparam logic [7:0]  ROT_WORK_RST  = 8'h00;
  localparam logic        ROT_CARRY_RST = 1'b0;
  localparam logic [7:0]  ROT_DATA_RST  = 8'h00;

endpackage : rot_pkg

// *** rot_unit.sv ***
// rotate datapath: memory byte rotations to memory or working register
//
// Operation
// - left carry rotate to memory: old carry to bit 0, bit 7 to carry.
// - left carry rotate to working register does so and leaves memory.
// - plain right rotate to memory moves bit 0 into bit 7, flags kept.
// - plain right rotate to working register, bit 0 to bit 7, flags kept.
// - right carry rotate to memory: old carry to bit 7, bit 0 to carry.
// - right carry rotate to working register does so with no memory write.
// - plain left rotate to memory moves bit 7 into bit 0, flags kept.
module rot_unit (
  // clock, reset, enable
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           clk_en,
  // decoder request
  input  wire rot_pkg::rot_op_e op,
  input  wire logic           op_valid,
  // memory read data
  input  wire logic [7:0]     mem_rdata,
  // memory write port
  output logic                mem_we,
  output logic [7:0]          mem_wdata,
  // working register and carry
  output logic [7:0]          working_register,
  output logic                carry
);

  logic [7:0] mem_wdata_r, mem_wdata_nxt;
  logic       mem_we_r, mem_we_nxt;
  logic [7:0] work_r, work_nxt;
  logic       carry_r, carry_nxt;
  logic [7:0] res;
  logic       to_mem;
  logic       to_work;
  logic       upd_c;
  logic       c_new;

  // rotated value, destination and carry for the current operation
  always_comb begin
    res     = mem_rdata;
    to_mem  = 1'b0;
    to_work = 1'b0;
    upd_c   = 1'b0;
    c_new   = carry_r;
    case (op)
      rot_pkg::ROT_LC_MEM, rot_pkg::ROT_LC_WORK: begin
        res     = {mem_rdata[6:0], carry_r};
        c_new   = mem_rdata[rot_pkg::ROT_MSB];
        upd_c   = 1'b1;
        to_mem  = (op == rot_pkg::ROT_LC_MEM);
        to_work = (op == rot_pkg::ROT_LC_WORK);
      end
      rot_pkg::ROT_R_MEM, rot_pkg::ROT_R_WORK: begin
        res     = {mem_rdata[0], mem_rdata[7:1]};
        to_mem  = (op == rot_pkg::ROT_R_MEM);
        to_work = (op == rot_pkg::ROT_R_WORK);
      end
      rot_pkg::ROT_RC_MEM, rot_pkg::ROT_RC_WORK: begin
        res     = {carry_r, mem_rdata[7:1]};
        c_new   = mem_rdata[rot_pkg::ROT_LSB];
        upd_c   = 1'b1;
        to_mem  = (op == rot_pkg::ROT_RC_MEM);
        to_work = (op == rot_pkg::ROT_RC_WORK);
      end
      rot_pkg::ROT_L_MEM: begin
        res    = {mem_rdata[6:0], mem_rdata[7]};
        to_mem = 1'b1;
      end
      default: begin
        res = mem_rdata;
      end
    endcase
  end

  // next state: everything commits together at the cycle end
  // carry is read from the register, so a carry op feeds the next op
  // directly; the write strobe drops after the next enabled cycle without a memory op
  always_comb begin
    mem_we_nxt    = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    work_nxt      = work_r;
    carry_nxt     = carry_r;
    if (op_valid) begin
      mem_we_nxt = to_mem;
      if (to_mem) begin
        mem_wdata_nxt = res;
      end
      if (to_work) begin
        work_nxt = res;
      end
      if (upd_c) begin
        carry_nxt = c_new;
      end
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= rot_pkg::ROT_DATA_RST;
      work_r      <= rot_pkg::ROT_WORK_RST;
      carry_r     <= rot_pkg::ROT_CARRY_RST;
    end else if (clk_en) begin
      mem_we_r    <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      work_r      <= work_nxt;
      carry_r     <= carry_nxt;
    end
  end

  // outputs straight from flip-flops
  assign mem_we           = mem_we_r;
  assign mem_wdata        = mem_wdata_r;
  assign working_register = work_r;
  assign carry            = carry_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_issue(rot_pkg::rot_op_e o);
    clk_en && op_valid && op == o;
  endsequence

  a_lc_mem_res: assert property (s_issue(rot_pkg::ROT_LC_MEM) |=>
    mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry)}
    && carry == $past(mem_rdata[7]))
    else $error("left carry rotate to memory wrong");
  a_lc_work_res: assert property (s_issue(rot_pkg::ROT_LC_WORK) |=>
    !mem_we && working_register == {$past(mem_rdata[6:0]), $past(carry)}
    && carry == $past(mem_rdata[7]))
    else $error("left carry rotate to working register wrong");
  a_r_mem_res: assert property (s_issue(rot_pkg::ROT_R_MEM) |=>
    mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
    && $stable(carry))
    else $error("right rotate to memory wrong");
  a_r_work_res: assert property (s_issue(rot_pkg::ROT_R_WORK) |=>
    !mem_we && $stable(carry)
    && working_register == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
    else $error("right rotate to working register wrong");
  a_rc_mem_res: assert property (s_issue(rot_pkg::ROT_RC_MEM) |=>
    mem_we && mem_wdata == {$past(carry), $past(mem_rdata[7:1])}
    && carry == $past(mem_rdata[0]))
    else $error("right carry rotate to memory wrong");
  a_rc_work_res: assert property (s_issue(rot_pkg::ROT_RC_WORK) |=>
    !mem_we && working_register == {$past(carry), $past(mem_rdata[7:1])}
    && carry == $past(mem_rdata[0]))
    else $error("right carry rotate to working register wrong");
  a_l_mem_res: assert property (s_issue(rot_pkg::ROT_L_MEM) |=>
    mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}
    && $stable(carry) && $stable(working_register))
    else $error("left rotate to memory wrong");
  a_idle_hold: assert property (clk_en && !op_valid |=>
    !mem_we && $stable(carry) && $stable(working_register))
    else $error("state changed without an operation");

  // operation groups used by the destination and flag checks
  sequence s_mem_issue;
    clk_en && op_valid && op inside {rot_pkg::ROT_LC_MEM,
      rot_pkg::ROT_R_MEM, rot_pkg::ROT_RC_MEM, rot_pkg::ROT_L_MEM};
  endsequence
  sequence s_work_issue;
    clk_en && op_valid && op inside {rot_pkg::ROT_LC_WORK,
      rot_pkg::ROT_R_WORK, rot_pkg::ROT_RC_WORK};
  endsequence
  sequence s_plain_issue;
    clk_en && op_valid && op inside {rot_pkg::ROT_R_MEM,
      rot_pkg::ROT_R_WORK, rot_pkg::ROT_L_MEM};
  endsequence

  // memory destinations never touch the working register
  a_mem_keep_work: assert property (s_mem_issue |=>
    $stable(working_register))
    else $error("memory rotate changed the working register");

  // working register destinations leave memory alone
  a_work_keep_mem: assert property (s_work_issue |=>
    !mem_we && $stable(mem_wdata))
    else $error("working register rotate wrote memory");

  // plain rotates never touch the carry flag
  a_plain_keep_c: assert property (s_plain_issue |=>
    $stable(carry))
    else $error("plain rotate changed the carry");

  // no-op code is refused without side effects
  a_none_quiet: assert property (s_issue(rot_pkg::ROT_NONE) |=>
    !mem_we && $stable(carry) && $stable(working_register)
    && $stable(mem_wdata))
    else $error("no-op code changed state");

  // low enable freezes every output, write strobe included
  a_freeze_hold: assert property (!clk_en |=>
    $stable(mem_we) && $stable(mem_wdata)
    && $stable(working_register) && $stable(carry))
    else $error("state moved while the enable was low");

  // the write strobe lasts one enabled cycle unless another memory op follows
  a_we_one_shot: assert property (mem_we && clk_en && !op_valid |=>
    !mem_we)
    else $error("memory write strobe stayed high");

  // idle cycles keep the last memory result on the write data
  a_idle_keep_data: assert property (clk_en && !op_valid |=>
    $stable(mem_wdata))
    else $error("memory write data moved without an operation");

  // outputs sit at their reset values while reset is held
  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
    !rst_b |-> !mem_we && mem_wdata == rot_pkg::ROT_DATA_RST
    && working_register == rot_pkg::ROT_WORK_RST
    && carry == rot_pkg::ROT_CARRY_RST)
    else $error("outputs not cleared by reset");

  // right carry rotate to the working register puts old carry on bit 7
  a_rc_work_top: assert property (s_issue(rot_pkg::ROT_RC_WORK) |=>
    working_register[7] == $past(carry))
    else $error("old carry missing from working register bit 7");

endmodule // rot_unit

// *** testbench.sv ***
// self-checking bench for the rotate unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic we; logic [7:0] wd; logic [7:0] w; logic c;}
    rot_exp_s;
  logic             clk = 0, rst_b = 0, clk_en = 0, op_valid = 0, load = 0;
  logic             mem_we, carry, vld_d = 0;
  logic [7:0]       ld = 8'h00, rdata, wdata, work;
  rot_pkg::rot_op_e op = rot_pkg::ROT_NONE;
  rot_exp_s         q[$], e, x, m = '0;
  int               failures = 0, checked = 0;

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;

  rot_unit u_rot_unit (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .op(op),
    .op_valid(op_valid), .mem_rdata(rdata), .mem_we(mem_we),
    .mem_wdata(wdata), .working_register(work), .carry(carry));
  rot_mem_model u_rot_mem_model (.clk(clk), .rst_b(rst_b), .load(load),
    .load_data(ld), .mem_we(mem_we), .mem_wdata(wdata), .mem_rdata(rdata));

  // compare one value and count it
  task automatic cmp(string n, logic [7:0] a, logic [7:0] b);
    checked++;
    if (a !== b) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, a, b);
    end
  endtask

  // final counts and verdict
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // drive one cycle and note the expected result of a taken op
  task automatic step(rot_pkg::rot_op_e o, logic v, logic en, logic [7:0] d);
    logic [7:0] r;
    logic       nc;
    @(posedge clk);
    #2;
    op = o; op_valid = v; clk_en = en; load = 1'b1; ld = d;
    r = m.w;
    nc = m.c;
    case (o)
      rot_pkg::ROT_LC_MEM, rot_pkg::ROT_LC_WORK: begin
        r = {d[6:0], m.c};
        nc = d[7];
      end
      rot_pkg::ROT_R_MEM, rot_pkg::ROT_R_WORK: r = {d[0], d[7:1]};
      rot_pkg::ROT_RC_MEM, rot_pkg::ROT_RC_WORK: begin
        r = {m.c, d[7:1]};
        nc = d[0];
      end
      rot_pkg::ROT_L_MEM: r = {d[6:0], d[7]};
      default: ;
    endcase
    e.we = o inside {rot_pkg::ROT_LC_MEM, rot_pkg::ROT_R_MEM,
                     rot_pkg::ROT_RC_MEM, rot_pkg::ROT_L_MEM};
    e.wd = r;
    e.c = nc;
    e.w = e.we ? m.w : r;
    if (v && en) begin
      m = e;
      q.push_back(e);
    end
  endtask

  // results show one cycle after a taken op
  always @(posedge clk) vld_d <= op_valid && clk_en && rst_b;
  always @(negedge clk) if (vld_d) begin
    if (q.size() == 0) begin
      failures++;
      $display("[FAIL] result expected none seen one");
    end else begin
      x = q.pop_front();
      cmp("mem_we", {7'h00, x.we}, {7'h00, mem_we});
      if (x.we) cmp("mem_wdata", x.wd, wdata);
      cmp("working_register", x.w, work);
      cmp("carry", {7'h00, x.c}, {7'h00, carry});
    end
  end

  // main sequence
  initial begin
    void'($urandom(21305));
    repeat (4) @(posedge clk);
    cmp("reset work", 8'h00, work);
    cmp("reset carry", 8'h00, {7'h00, carry});
    #2 rst_b = 1'b1;
    for (int i = 0; i < 16; i++)
      step(rot_pkg::rot_op_e'(3'(i)), 1'b1, 1'b1, 8'($urandom));
    $display("test back to back ops done");
    repeat (300) step(rot_pkg::rot_op_e'(3'($urandom)), 1'($urandom),
                      ($urandom % 4) != 0, 8'($urandom));
    $display("test random ops done");
    step(rot_pkg::ROT_NONE, 1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 5 && q.size() != 0; i++) @(posedge clk);
    if (q.size() != 0) failures++;
    conclude();
  end
endmodule // testbench
